// ===== stream_framer_pkg.sv
// Purpose: constants and carriers for the lock-in udp stream framer
// Assumes: one 50 MHz clock, all inputs come from logic on that clock
// Notes: header layout is fixed big-endian, payload order is selectable

package stream_framer_pkg;

  localparam int BIT_OVL = 24;
  localparam int BIT_ERR = 25;
  localparam int BIT_LE = 28;
  localparam int BIT_CKSUM = 29;
  localparam logic [15:0] DEFAULT_PORT = 16'h0749;
  localparam logic [4:0] RATE_CODE_MAX = 5'h1F;
  localparam logic [1:0] HDR_LAST_BYTE = 2'h3;
  localparam logic [10:0] PAY_1024 = 11'h400;
  localparam logic [10:0] PAY_512 = 11'h200;
  localparam logic [10:0] PAY_256 = 11'h100;
  localparam logic [10:0] PAY_128 = 11'h080;

  typedef struct packed {
    logic [31:0] x;
    logic [31:0] y;
    logic [31:0] r;
    logic [31:0] th;
    logic [15:0] xi;
    logic [15:0] yi;
    logic [15:0] ri;
    logic [15:0] thi;
  } sample_s;

  typedef struct packed {
    logic in_ovl;
    logic sync_on;
    logic sync_ovl;
    logic out_ovl;
    logic pll_unlock;
    logic sync_range;
  } flags_s;

  typedef struct packed {
    logic [2:0] content;
    logic [1:0] len_code;
    logic little_end;
    logic cksum_en;
    logic [4:0] rate_base;
    logic [4:0] rate_shift;
  } cfg_s;

  typedef struct packed {
    logic [7:0] data;
    logic first;
    logic last;
  } byte_s;

  typedef enum logic [1:0] {S_IDLE, S_HDR, S_PAY, S_WAIT} state_e;

  function automatic logic [10:0] len_bytes(input logic [1:0] code);
    case (code)
      2'h0: len_bytes = PAY_1024;
      2'h1: len_bytes = PAY_512;
      2'h2: len_bytes = PAY_256;
      default: len_bytes = PAY_128;
    endcase
  endfunction : len_bytes

endpackage : stream_framer_pkg

// ===== lockin_udp_stream_framer.sv
// Purpose: frames lock-in samples into udp stream payload bytes
// Assumes: network stack below takes bytes with first/last marks
// Notes: a stream disable finishes the packet under way
`timescale 1ns/100ps
`default_nettype none

module lockin_udp_stream_framer (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic stream_cmd_valid,
  input wire logic stream_cmd_on,
  input wire logic [31:0] stream_cmd_ip,
  input wire logic port_cmd_valid,
  input wire logic [15:0] port_cmd_value,
  input wire stream_framer_pkg::cfg_s cfg,
  input wire stream_framer_pkg::flags_s flags,
  input wire logic sample_valid,
  input wire stream_framer_pkg::sample_s sample,
  output logic sample_ready,
  output logic out_valid,
  input wire logic out_ready,
  output stream_framer_pkg::byte_s out_byte,
  output logic [31:0] dest_ip,
  output logic [15:0] dest_port,
  output logic [31:0] header,
  output logic streaming
);
  import stream_framer_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state

  state_e state_reg, state_next;
  sample_s smp_reg;
  logic [31:0] hdr_reg;
  logic [7:0] counter_reg;
  logic enabled_reg;
  logic [31:0] ip_reg;
  logic [15:0] port_reg;
  logic pk_le_reg, pk_int_reg;
  logic [1:0] pk_nch_reg, pk_base_reg;
  logic [1:0] hb_reg, ch_reg, bi_reg;
  logic [10:0] pay_left_reg;
  logic smp_ready_reg;

  ////////////////////////////////////////////////////////////////////////////
  // decode

  wire restart = stream_cmd_valid & stream_cmd_on;
  wire accept = sample_valid & smp_ready_reg;
  wire start_pkt = accept & (state_reg == S_IDLE);
  wire [5:0] rate_sum = {1'b0, cfg.rate_base} + {1'b0, cfg.rate_shift};
  // clamp so a large subsample request never wraps the 5-bit code
  wire [4:0] rate_code = (rate_sum > {1'b0, RATE_CODE_MAX}) ?
                         RATE_CODE_MAX : rate_sum[4:0];
  wire ovl_now = flags.in_ovl | (flags.sync_on & flags.sync_ovl) |
                 (cfg.content[2] & flags.out_ovl);
  wire err_now = flags.pll_unlock | flags.sync_range;
  wire [7:0] cnt_use = restart ? 8'h00 : counter_reg;
  wire [31:0] hdr_next = {2'h0, cfg.cksum_en, cfg.little_end, 2'h0,
                          err_now, ovl_now, 3'h0, rate_code,
                          2'h0, cfg.len_code, 1'b0, cfg.content,
                          cnt_use};
  wire [1:0] nch_next = (cfg.content[1:0] == 2'h0) ? 2'h0 :
                        (cfg.content[1:0] == 2'h3) ? 2'h3 : 2'h1;
  wire [1:0] base_next = (cfg.content[1:0] == 2'h2) ? 2'h2 : 2'h0;

  // payload byte selection
  wire [1:0] ch_idx = 2'(pk_base_reg + ch_reg);
  wire [31:0] word_f = (ch_idx == 2'h0) ? smp_reg.x :
                       (ch_idx == 2'h1) ? smp_reg.y :
                       (ch_idx == 2'h2) ? smp_reg.r : smp_reg.th;
  wire [15:0] word_i = (ch_idx == 2'h0) ? smp_reg.xi :
                       (ch_idx == 2'h1) ? smp_reg.yi :
                       (ch_idx == 2'h2) ? smp_reg.ri : smp_reg.thi;
  wire [1:0] wb_last = pk_int_reg ? 2'h1 : 2'h3;
  wire [1:0] lane = pk_le_reg ? bi_reg : 2'(wb_last - bi_reg);
  wire [31:0] word_sel = pk_int_reg ? {16'h0000, word_i} : word_f;
  wire [31:0] pay_shift = word_sel >> {lane, 3'h0};
  wire [31:0] hdr_shift = hdr_reg >> {(HDR_LAST_BYTE - hb_reg), 3'h0};
  wire in_hdr = (state_reg == S_HDR);
  wire gen_valid = in_hdr | (state_reg == S_PAY);
  wire pay_done = (pay_left_reg == 11'h001);
  wire word_done = (bi_reg == wb_last);
  wire smp_done = word_done & (ch_reg == pk_nch_reg);
  byte_s gen_byte;
  assign gen_byte.data = in_hdr ? hdr_shift[7:0] : pay_shift[7:0];
  assign gen_byte.first = in_hdr & (hb_reg == 2'h0);
  assign gen_byte.last = ~in_hdr & pay_done;
  logic buf_ready;
  wire push = gen_valid & buf_ready;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE: begin
        if (start_pkt) begin
          state_next = S_HDR;
        end
      end
      S_HDR: begin
        if (push && hb_reg == HDR_LAST_BYTE) begin
          state_next = S_PAY;
        end
      end
      S_PAY: begin
        if (push && pay_done) begin
          state_next = S_IDLE;
        end else if (push && smp_done) begin
          state_next = S_WAIT;
        end
      end
      S_WAIT: begin
        if (accept) begin
          state_next = S_PAY;
        end
      end
      default: state_next = S_IDLE;
    endcase
  end

  wire en_next = stream_cmd_valid ? stream_cmd_on : enabled_reg;
  wire ready_next = (state_next == S_WAIT) |
                    ((state_next == S_IDLE) & en_next);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= S_IDLE;
      enabled_reg <= 1'b0;
      smp_ready_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      enabled_reg <= en_next;
      smp_ready_reg <= ready_next;
    end
  end

  // ip and port are captured from the commands, held between packets
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ip_reg <= 32'h0000_0000;
      port_reg <= DEFAULT_PORT;
    end else begin
      if (restart) begin
        ip_reg <= stream_cmd_ip;
      end
      if (port_cmd_valid) begin
        port_reg <= port_cmd_value;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      counter_reg <= 8'h00;
    end else if (start_pkt) begin
      counter_reg <= cnt_use + 8'h01;
    end else if (restart) begin
      counter_reg <= 8'h00;
    end
  end

  // config is frozen per packet so a mid-packet change cannot tear it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hdr_reg <= 32'h0000_0000;
      pk_le_reg <= 1'b0;
      pk_int_reg <= 1'b0;
      pk_nch_reg <= 2'h0;
      pk_base_reg <= 2'h0;
    end else if (start_pkt) begin
      hdr_reg <= hdr_next;
      pk_le_reg <= cfg.little_end;
      pk_int_reg <= cfg.content[2];
      pk_nch_reg <= nch_next;
      pk_base_reg <= base_next;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      smp_reg <= '0;
    end else if (accept) begin
      smp_reg <= sample;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hb_reg <= 2'h0;
      pay_left_reg <= 11'h000;
    end else if (start_pkt) begin
      hb_reg <= 2'h0;
      pay_left_reg <= len_bytes(cfg.len_code);
    end else if (push) begin
      hb_reg <= in_hdr ? hb_reg + 2'h1 : hb_reg;
      pay_left_reg <= in_hdr ? pay_left_reg : pay_left_reg - 11'h001;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ch_reg <= 2'h0;
      bi_reg <= 2'h0;
    end else if (start_pkt) begin
      ch_reg <= 2'h0;
      bi_reg <= 2'h0;
    end else if (push && !in_hdr) begin
      bi_reg <= word_done ? 2'h0 : bi_reg + 2'h1;
      ch_reg <= smp_done ? 2'h0 : (word_done ? ch_reg + 2'h1 : ch_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // two-entry skid buffer: one byte per cycle covers 50 MB/s at 50 MHz

  byte_s head_reg, skid_reg;
  logic head_valid_reg, skid_valid_reg;
  wire pop = head_valid_reg & out_ready;
  wire head_free = ~head_valid_reg | pop;
  assign buf_ready = ~skid_valid_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      head_reg <= '0;
      head_valid_reg <= 1'b0;
      skid_reg <= '0;
      skid_valid_reg <= 1'b0;
    end else if (head_free) begin
      head_reg <= skid_valid_reg ? skid_reg : gen_byte;
      head_valid_reg <= skid_valid_reg | push;
      skid_valid_reg <= 1'b0;
    end else if (push) begin
      skid_reg <= gen_byte;
      skid_valid_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign sample_ready = smp_ready_reg;
  assign out_valid = head_valid_reg;
  assign out_byte = head_reg;
  assign dest_ip = ip_reg;
  assign dest_port = port_reg;
  assign header = hdr_reg;
  assign streaming = enabled_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_hdr_zero_bits: assert property (@(posedge clk)
    disable iff (!arst_n)
    start_pkt |=> (hdr_reg[31:30] == 2'h0) && (hdr_reg[27:26] == 2'h0)
      && (hdr_reg[23:21] == 3'h0) && (hdr_reg[15:14] == 2'h0))
    else $error("undefined header bits not zero");

  a_hdr_first_byte: assert property (@(posedge clk)
    disable iff (!arst_n)
    (push && gen_byte.first) |-> gen_byte.data == hdr_reg[31:24])
    else $error("header not sent high byte first");

  a_counter_step: assert property (@(posedge clk)
    disable iff (!arst_n)
    (start_pkt && !restart) |=>
      hdr_reg[7:0] == $past(counter_reg)
      && counter_reg == $past(counter_reg) + 8'h01)
    else $error("packet counter did not advance by one");

  a_counter_restart: assert property (@(posedge clk)
    disable iff (!arst_n)
    (restart && start_pkt) |=> hdr_reg[7:0] == 8'h00)
    else $error("counter not restarted on enable");

  a_len_load: assert property (@(posedge clk)
    disable iff (!arst_n)
    start_pkt |=> pay_left_reg == (11'h400 >> hdr_reg[13:12]))
    else $error("payload length does not match length code");

  a_endian_bits: assert property (@(posedge clk)
    disable iff (!arst_n)
    (state_reg == S_PAY) |-> hdr_reg[BIT_LE] == pk_le_reg
      && hdr_reg[11:8] == {1'b0, pk_int_reg, 2'h0}
         + {2'h0, pk_base_reg == 2'h2 ? 2'h2 : pk_nch_reg})
    else $error("header endian or content disagrees with payload");

  a_ovl_flag: assert property (@(posedge clk)
    disable iff (!arst_n)
    start_pkt |=> hdr_reg[BIT_OVL] == $past(ovl_now)
      && hdr_reg[BIT_ERR] == $past(err_now)
      && hdr_reg[BIT_CKSUM] == $past(cfg.cksum_en))
    else $error("status flags not taken at first sample");

  a_rate_clamp: assert property (@(posedge clk)
    disable iff (!arst_n)
    start_pkt |=> hdr_reg[20:16] == ($past(rate_sum) > 6'h1F ?
      5'h1F : $past(rate_sum[4:0])))
    else $error("rate code not the subsampled rate");

  a_le_int_swap: assert property (@(posedge clk)
    disable iff (!arst_n)
    (push && state_reg == S_PAY && pk_int_reg && !pk_le_reg
      && bi_reg == 2'h0) |-> gen_byte.data == word_i[15:8])
    else $error("integer high byte not first in big-endian");

  a_out_hold: assert property (@(posedge clk)
    disable iff (!arst_n)
    (out_valid && !out_ready) |=> out_valid && $stable(out_byte))
    else $error("output byte changed while stalled");

  a_port_load: assert property (@(posedge clk)
    disable iff (!arst_n)
    port_cmd_valid |=> dest_port == $past(port_cmd_value))
    else $error("destination port not taken");

  a_ip_load: assert property (@(posedge clk)
    disable iff (!arst_n)
    restart |=> dest_ip == $past(stream_cmd_ip))
    else $error("destination ip not taken from enable");

  // a disabled, idle framer must not take a sample
  a_ready_off: assert property (@(posedge clk)
    disable iff (!arst_n)
    (state_reg == S_IDLE && !enabled_reg) |-> !sample_ready)
    else $error("sample taken while stream disabled");

  a_busy_no_take: assert property (@(posedge clk)
    disable iff (!arst_n)
    (state_reg == S_HDR || state_reg == S_PAY) |-> !sample_ready)
    else $error("sample ready while bytes still pending");

  a_pkt_end: assert property (@(posedge clk)
    disable iff (!arst_n)
    (push && state_reg == S_PAY && pay_done) |->
      gen_byte.last ##1 state_reg == S_IDLE)
    else $error("packet did not end on its final byte");

  a_float_lane: assert property (@(posedge clk)
    disable iff (!arst_n)
    (push && state_reg == S_PAY && !pk_int_reg && bi_reg == 2'h0) |->
      gen_byte.data == (pk_le_reg ? word_f[7:0] : word_f[31:24]))
    else $error("float word not started on the right byte");

  a_skid_keep: assert property (@(posedge clk)
    disable iff (!arst_n)
    (push && !head_free) |=> skid_valid_reg && skid_reg == $past(gen_byte))
    else $error("byte lost while output stalled");

endmodule : lockin_udp_stream_framer

`default_nettype wire

// ===== stream_receiver.sv
// Purpose: host side model that takes the framed stream bytes
// Assumes: bytes come as byte_s with a valid/ready handshake
// Notes: stalls one cycle in four, and fully while hold is high
`timescale 1ns/100ps
`default_nettype none

module stream_receiver (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic hold,
  input wire logic clear,
  input wire logic drop,
  input wire logic out_valid,
  input wire stream_framer_pkg::byte_s out_byte,
  output logic out_ready
);
  import stream_framer_pkg::*;
  logic [1:0] cyc_reg;
  int count_reg;
  logic seen_last_reg;
  byte_s mem [0:1027];
  // drop stands for a failed checksum: the whole packet goes, not a tail
  wire discard = drop && out_byte.last && mem[0].data[5];

  // regular stalls keep the two-entry buffer busy
  assign out_ready = !hold && (cyc_reg != 2'h3);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cyc_reg <= 2'h0;
      count_reg <= 0;
      seen_last_reg <= 1'b0;
    end else begin
      cyc_reg <= cyc_reg + 2'h1;
      if (clear) begin
        count_reg <= 0;
        seen_last_reg <= 1'b0;
      end else if (out_valid && out_ready) begin
        mem[count_reg] <= out_byte;
        count_reg <= discard ? 0 : count_reg + 1;
        seen_last_reg <= seen_last_reg | out_byte.last;
      end
    end
  end
endmodule : stream_receiver

`default_nettype wire

// ===== lockin_udp_stream_framer_test.sv
// Purpose: checks packets built by the lock-in udp stream framer
// Assumes: receiver model stalls often; expected bytes come from pattern
// Notes: flags are inverted after the first sample of each packet
`timescale 1ns/100ps
`default_nettype none

module lockin_udp_stream_framer_test;
  import stream_framer_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic stream_cmd_valid = 1'b0;
  logic stream_cmd_on = 1'b0;
  logic [31:0] stream_cmd_ip = 32'h0;
  logic port_cmd_valid = 1'b0;
  logic [15:0] port_cmd_value = 16'h0;
  cfg_s cfg = '0;
  flags_s flags = '0;
  logic sample_valid = 1'b0;
  sample_s sample = '0;
  logic hold = 1'b0;
  logic clear = 1'b0;
  logic drop = 1'b0;
  logic sample_ready, out_valid, out_ready, streaming;
  byte_s out_byte;
  logic [31:0] dest_ip, header;
  logic [15:0] dest_port;
  int n_fail = 0;
  int samples_checked = 0;
  int cycles = 0;

  always #10 clk = ~clk;

  lockin_udp_stream_framer lockin_udp_stream_framer_inst (.clk(clk),
    .arst_n(arst_n), .stream_cmd_valid(stream_cmd_valid),
    .stream_cmd_on(stream_cmd_on), .stream_cmd_ip(stream_cmd_ip),
    .port_cmd_valid(port_cmd_valid), .port_cmd_value(port_cmd_value),
    .cfg(cfg), .flags(flags), .sample_valid(sample_valid),
    .sample(sample), .sample_ready(sample_ready), .out_valid(out_valid),
    .out_ready(out_ready), .out_byte(out_byte), .dest_ip(dest_ip),
    .dest_port(dest_port), .header(header), .streaming(streaming));

  stream_receiver stream_receiver_inst (.clk(clk), .arst_n(arst_n),
    .hold(hold), .clear(clear), .drop(drop), .out_valid(out_valid),
    .out_byte(out_byte), .out_ready(out_ready));

  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  // ceiling well above the roughly 7k cycles the packets need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_fail++;
      results();
    end
  end

  task automatic check(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", name, exp, got);
      n_fail++;
    end
  endtask : check

  task automatic send_stream_cmd(input logic on, input logic [31:0] ip);
    stream_cmd_valid <= 1'b1;
    stream_cmd_on <= on;
    stream_cmd_ip <= ip;
    @(posedge clk);
    stream_cmd_valid <= 1'b0;
    @(posedge clk);
  endtask : send_stream_cmd

  function automatic logic [31:0] chv(input int c, input int k,
                                      input logic wi);
    logic [7:0] cb;
    logic [7:0] kb;
    cb = 8'(c);
    kb = 8'(k);
    if (wi) chv = {16'h0, 8'h20 + cb, kb};
    else chv = {8'h10 + cb, kb, 8'h5A, 8'hC0 + cb};
  endfunction : chv

  function automatic sample_s mk(input int k);
    mk.x = chv(0, k, 1'b0);
    mk.y = chv(1, k, 1'b0);
    mk.r = chv(2, k, 1'b0);
    mk.th = chv(3, k, 1'b0);
    mk.xi = 16'(chv(0, k, 1'b1));
    mk.yi = 16'(chv(1, k, 1'b1));
    mk.ri = 16'(chv(2, k, 1'b1));
    mk.thi = 16'(chv(3, k, 1'b1));
  endfunction : mk

  // content i, length code i mod 4, mixed order, checksum and flags
  task automatic run_packet(input int i, input logic [7:0] ctr);
    logic [3:0] mask;
    logic [5:0] f;
    logic [5:0] rs;
    logic [7:0] st;
    logic [31:0] hdr;
    logic [31:0] v;
    logic [7:0] gb;
    int w, nb, ns, j, p, ne;
    cfg_s c;
    c.content = 3'(i);
    c.len_code = 2'(i);
    c.little_end = (i % 3 == 1);
    c.cksum_en = i[1];
    c.rate_base = 5'(i * 4);
    c.rate_shift = 5'(i * 3);
    f = 6'(i * 13 + 5);
    mask = (i % 4 == 0) ? 4'h1 : (i % 4 == 1) ? 4'h3 :
           (i % 4 == 2) ? 4'hC : 4'hF;
    w = c.content[2] ? 2 : 4;
    nb = 1024 >> c.len_code;
    ns = nb / (w * $countones(mask));
    // packet 3 carries a checksum and is made to fail it at the host
    ne = (i == 3) ? 0 : nb + 4;
    st = {2'h0, c.cksum_en, c.little_end, 2'h0, f[1] | f[0],
          f[5] | (f[4] & f[3]) | (f[2] & c.content[2])};
    rs = 6'(c.rate_base) + 6'(c.rate_shift);
    hdr = {st, 3'h0, (rs > 6'h1F) ? 5'h1F : rs[4:0], 2'h0, c.len_code,
           1'h0, c.content, ctr};
    @(posedge clk);
    clear <= 1'b1;
    drop <= (i == 3);
    cfg <= c;
    flags <= f;
    @(posedge clk);
    clear <= 1'b0;
    for (int k = 0; k < ns; k++) begin
      sample <= mk(k);
      sample_valid <= 1'b1;
      do @(negedge clk); while (!sample_ready);
      @(posedge clk);
      if (k == 0) flags <= ~f;
      if (k == 1 || k == ns - 1) sample_valid <= 1'b0;
      if (k == 1) begin
        hold <= 1'b1;
        repeat (30) @(posedge clk);
        hold <= 1'b0;
      end
    end
    j = 0;
    while (!stream_receiver_inst.seen_last_reg && j < 4000) begin
      @(negedge clk);
      j++;
    end
    repeat (8) @(negedge clk);
    check("byte count", ne, stream_receiver_inst.count_reg);
    check("header", hdr, header);
    for (j = 0; j < 4; j++) begin
      gb = stream_receiver_inst.mem[j].data;
      check("header byte", hdr[31 - 8 * j -: 8], gb);
    end
    check("first mark", 32'h1, stream_receiver_inst.mem[0].first);
    check("early last", 32'h0, stream_receiver_inst.mem[nb + 2].last);
    check("last mark", 32'h1, stream_receiver_inst.mem[nb + 3].last);
    p = 4;
    for (int k = 0; k < ns; k++) begin
      for (int ch = 0; ch < 4; ch++) begin
        if (mask[ch]) begin
          v = chv(ch, k, c.content[2]);
          for (int b = 0; b < w; b++) begin
            j = c.little_end ? b : w - 1 - b;
            gb = stream_receiver_inst.mem[p].data;
            check("payload", v[8 * j +: 8], gb);
            p++;
          end
        end
      end
    end
  endtask : run_packet

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    check("dest_port", 32'h0749, dest_port);
    check("sample_ready", 32'h0, sample_ready);
    port_cmd_valid <= 1'b1;
    port_cmd_value <= 16'h2A31;
    @(posedge clk);
    port_cmd_valid <= 1'b0;
    @(posedge clk);
    check("dest_port", 32'h2A31, dest_port);
    send_stream_cmd(1'b1, 32'hC0A80A07);
    check("dest_ip", 32'hC0A80A07, dest_ip);
    check("streaming", 32'h1, streaming);
    for (int i = 0; i < 8; i++) begin
      run_packet(i, 8'(i));
    end
    send_stream_cmd(1'b1, 32'h0A000002);
    check("dest_ip", 32'h0A000002, dest_ip);
    run_packet(5, 8'h0);
    send_stream_cmd(1'b0, 32'h0);
    check("streaming", 32'h0, streaming);
    sample_valid <= 1'b1;
    repeat (5) begin
      @(negedge clk);
      check("sample_ready", 32'h0, sample_ready);
    end
    results();
  end
endmodule : lockin_udp_stream_framer_test

`default_nettype wire
